// File: rtl/host_port.sv
// Host port: host pin protocol, control word, DMA request path
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module host_port
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        hostPortResetN,
	input  wire logic        addrDataMuxSelect,
	input  wire logic [15:0] hostDataLinesIn,
	output      logic [15:0] hostDataLinesOut,
	output      logic        hostDataLinesOeN,
	input  wire logic [17:0] hostAddressLines,
	input  wire logic        hostDataStrobeOneN,
	input  wire logic        hostDataStrobeTwoN,
	input  wire logic        hostChipSelectN,
	input  wire logic [1:0]  hostAccessType,
	input  wire logic        hostReadNotWrite,
	input  wire logic        hostAddrLatchN,
	output      logic        hostHoldOff,
	output      logic        toHostInterruptN,
	input  wire logic        dspCtrlWrite,
	input  wire logic [15:0] dspCtrlWData,
	output      logic [15:0] dspCtrlRData,
	output      logic        toDspInterrupt,
	output      logic        dspWakeRequest,
	input  wire logic [2:0]  lowPowerState,
	input  wire logic        cpuHalted,
	output      logic        memClockOn,
	input  wire logic        coreResetPinsHigh,
	input  wire logic        subsystemSelect,
	output      logic [1:0]  coreHold,
	output      logic        dmaReqValid,
	input  wire logic        dmaReqReady,
	output      logic        dmaReqWrite,
	output      logic [17:0] dmaReqAddr,
	output      logic [15:0] dmaReqData,
	input  wire logic        dmaRdValid,
	input  wire logic [15:0] dmaRdData
);

	////////////////////////////////////////////////////////////////////////
	// Reset, strobes and access decode

	logic                          portRst;
	logic                          strobeOn;
	logic                          startEdge;
	logic                          latchFall;
	logic [1:0]                    effType;
	logic                          effRead;
	logic                          hostCtrlWr;
	logic                          isDataAccess;
	logic [15:0]                   ctrlWord;
	logic                          fifoInReady;
	logic                          fifoInValid;
	logic [`HP_FIFO_W-1:0]         fifoInData;
	logic [`HP_FIFO_W-1:0]         fifoOutData;
	logic                          releaseWr;
	logic                          inIdleLight;

	host_port_pkg::access_state_t  state_ff;
	host_port_pkg::access_state_t  nxt_state;
	logic                          isRead_ff;
	logic                          nxt_isRead;
	logic                          isAuto_ff;
	logic                          nxt_isAuto;
	logic [17:0]                   accAddr_ff;
	logic [17:0]                   nxt_accAddr;
	logic [15:0]                   accData_ff;
	logic [15:0]                   nxt_accData;
	logic [17:0]                   pointer_ff;
	logic [17:0]                   nxt_pointer;
	logic [15:0]                   hostDataOut_ff;
	logic [15:0]                   nxt_hostDataOut;
	logic                          strobePrev_ff;
	logic                          latchPrev_ff;
	logic [1:0]                    typeHeld_ff;
	logic [1:0]                    nxt_typeHeld;
	logic                          rwHeld_ff;
	logic                          nxt_rwHeld;
	logic                          useHeld_ff;
	logic                          nxt_useHeld;

	logic                          toHostBit_ff;
	logic                          nxt_toHostBit;
	logic                          prefetch_ff;
	logic                          nxt_prefetch;
	logic                          toDsp_ff;
	logic                          nxt_toDsp;
	logic                          wake_ff;
	logic                          nxt_wake;
	logic [15:0]                   dspRData_ff;

	logic [1:0]                    coreHold_ff;
	logic [1:0]                    nxt_coreHold;
	logic                          strapDone_ff;
	logic                          memClock_ff;
	logic                          nxt_memClock;

	// Port reset is separate from the core's, so loading can run early
	assign portRst = srst | ~hostPortResetN;

	assign strobeOn  = ~hostChipSelectN &
		(~hostDataStrobeOneN | ~hostDataStrobeTwoN);
	assign startEdge = strobeOn & ~strobePrev_ff;
	assign latchFall = ~hostAddrLatchN & latchPrev_ff;

	// Type and direction come from the address latch if it was used
	assign effType = useHeld_ff ? typeHeld_ff : hostAccessType;
	assign effRead = useHeld_ff ? rwHeld_ff : hostReadNotWrite;

	// Separate mode has no type lines: only the data window is reached
	assign isDataAccess = ~addrDataMuxSelect |
		(effType == `HP_TYPE_DATA_INC) |
		(effType == `HP_TYPE_DATA);

	assign hostCtrlWr = (state_ff == host_port_pkg::ST_IDLE) & startEdge &
		addrDataMuxSelect & (effType == `HP_TYPE_CTRL) & ~effRead;

	always_comb
	begin
		ctrlWord = `HP_WORD_RST;
		ctrlWord[`HP_CTRL_PAGE_HI:`HP_CTRL_PAGE_LO] = pointer_ff[17:16];
		ctrlWord[`HP_CTRL_PREFETCH] = prefetch_ff;
		ctrlWord[`HP_CTRL_TODSP]    = 1'b0;
		ctrlWord[`HP_CTRL_TOHOST]   = toHostBit_ff;
	end

	////////////////////////////////////////////////////////////////////////
	// Host access state machine

	always_comb
	begin
		nxt_state       = state_ff;
		nxt_isRead      = isRead_ff;
		nxt_isAuto      = isAuto_ff;
		nxt_accAddr     = accAddr_ff;
		nxt_accData     = accData_ff;
		nxt_pointer     = pointer_ff;
		nxt_hostDataOut = hostDataOut_ff;
		nxt_typeHeld    = typeHeld_ff;
		nxt_rwHeld      = rwHeld_ff;
		nxt_useHeld     = useHeld_ff;
		if (latchFall && (state_ff == host_port_pkg::ST_IDLE) &&
			addrDataMuxSelect)
		begin
			nxt_typeHeld = hostAccessType;
			nxt_rwHeld   = hostReadNotWrite;
			nxt_useHeld  = 1'b1;
		end
		// Halt of the CPU does not enter here: service goes on regardless
		case (state_ff)
			host_port_pkg::ST_IDLE:
			begin
				if (startEdge)
				begin
					nxt_isRead = effRead;
					nxt_isAuto = 1'b0;
					nxt_state  = host_port_pkg::ST_END;
					if (isDataAccess)
					begin
						// Memory space only; there is no I/O select
						nxt_accAddr = addrDataMuxSelect ?
							pointer_ff : hostAddressLines;
						nxt_accData = hostDataLinesIn;
						nxt_isAuto  = addrDataMuxSelect &
							(effType == `HP_TYPE_DATA_INC);
						if (!addrDataMuxSelect)
							nxt_pointer = hostAddressLines;
						nxt_state = host_port_pkg::ST_PUSH;
					end
					else if (effType == `HP_TYPE_CTRL)
					begin
						if (effRead)
							nxt_hostDataOut = ctrlWord;
						else
							nxt_pointer[17:16] = hostDataLinesIn[
								`HP_CTRL_PAGE_HI:`HP_CTRL_PAGE_LO];
					end
					else
					begin
						if (effRead)
							nxt_hostDataOut = pointer_ff[15:0];
						else
							nxt_pointer[15:0] = hostDataLinesIn;
					end
				end
			end
			host_port_pkg::ST_PUSH:
			begin
				if (fifoInReady)
				begin
					if (isRead_ff)
						nxt_state = host_port_pkg::ST_WAIT;
					else
					begin
						if (isAuto_ff)
							nxt_pointer = pointer_ff + 18'h00001;
						nxt_state = host_port_pkg::ST_END;
					end
				end
			end
			host_port_pkg::ST_WAIT:
			begin
				if (dmaRdValid)
				begin
					nxt_hostDataOut = dmaRdData;
					if (isAuto_ff)
						nxt_pointer = pointer_ff + 18'h00001;
					nxt_state = host_port_pkg::ST_END;
				end
			end
			host_port_pkg::ST_END:
			begin
				if (!strobeOn)
				begin
					nxt_useHeld = 1'b0;
					nxt_state   = host_port_pkg::ST_IDLE;
				end
			end
			default:
				nxt_state = host_port_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (portRst)
		begin
			state_ff       <= host_port_pkg::ST_IDLE;
			isRead_ff      <= 1'b0;
			isAuto_ff      <= 1'b0;
			accAddr_ff     <= `HP_POINTER_RST;
			accData_ff     <= `HP_WORD_RST;
			pointer_ff     <= `HP_POINTER_RST;
			hostDataOut_ff <= `HP_WORD_RST;
			strobePrev_ff  <= 1'b0;
			latchPrev_ff   <= 1'b1;
			typeHeld_ff    <= `HP_TYPE_CTRL;
			rwHeld_ff      <= 1'b0;
			useHeld_ff     <= 1'b0;
		end
		else
		begin
			state_ff       <= nxt_state;
			isRead_ff      <= nxt_isRead;
			isAuto_ff      <= nxt_isAuto;
			accAddr_ff     <= nxt_accAddr;
			accData_ff     <= nxt_accData;
			pointer_ff     <= nxt_pointer;
			hostDataOut_ff <= nxt_hostDataOut;
			strobePrev_ff  <= strobeOn;
			latchPrev_ff   <= hostAddrLatchN;
			typeHeld_ff    <= nxt_typeHeld;
			rwHeld_ff      <= nxt_rwHeld;
			useHeld_ff     <= nxt_useHeld;
		end
	end

	// Host waits while the request is queued or the read is outstanding
	assign hostHoldOff = (state_ff == host_port_pkg::ST_PUSH) |
		(state_ff == host_port_pkg::ST_WAIT) |
		((state_ff == host_port_pkg::ST_IDLE) & startEdge);
	assign hostDataLinesOut = hostDataOut_ff;
	assign hostDataLinesOeN = ~((state_ff == host_port_pkg::ST_END) &
		isRead_ff & strobeOn);

	////////////////////////////////////////////////////////////////////////
	// DMA request queue

	assign fifoInValid = (state_ff == host_port_pkg::ST_PUSH);
	assign fifoInData  = {~isRead_ff, accAddr_ff, accData_ff};

	host_port_fifo
	#(
		.WIDTH (`HP_FIFO_W),
		.DEPTH (`HP_FIFO_DEPTH)
	)
	u_fifo
	(
		.clk      (clk),
		.srst     (portRst),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (fifoInData),
		.outValid (dmaReqValid),
		.outReady (dmaReqReady),
		.outData  (fifoOutData)
	);

	assign dmaReqWrite = fifoOutData[34];
	assign dmaReqAddr  = fifoOutData[33:16];
	assign dmaReqData  = fifoOutData[15:0];

	////////////////////////////////////////////////////////////////////////
	// Interrupts in both directions

	always_comb
	begin
		nxt_toHostBit = toHostBit_ff;
		nxt_prefetch  = prefetch_ff;
		// A zero in either writer's data changes nothing; set beats clear
		if (dspCtrlWrite && dspCtrlWData[`HP_CTRL_TOHOST])
			nxt_toHostBit = 1'b1;
		else if (hostCtrlWr && hostDataLinesIn[`HP_CTRL_TOHOST])
			nxt_toHostBit = 1'b0;
		if (hostCtrlWr)
			nxt_prefetch = hostDataLinesIn[`HP_CTRL_PREFETCH];
		nxt_toDsp = hostCtrlWr & hostDataLinesIn[`HP_CTRL_TODSP];
		nxt_wake  = nxt_toDsp & (|lowPowerState);
	end

	always_ff @(posedge clk)
	begin
		if (portRst)
		begin
			toHostBit_ff <= 1'b0;
			prefetch_ff  <= 1'b0;
			toDsp_ff     <= 1'b0;
			wake_ff      <= 1'b0;
			dspRData_ff  <= `HP_WORD_RST;
		end
		else
		begin
			toHostBit_ff <= nxt_toHostBit;
			prefetch_ff  <= nxt_prefetch;
			toDsp_ff     <= nxt_toDsp;
			wake_ff      <= nxt_wake;
			dspRData_ff  <= ctrlWord;
		end
	end

	assign toHostInterruptN = ~toHostBit_ff;
	assign toDspInterrupt   = toDsp_ff;
	assign dspWakeRequest   = wake_ff;
	assign dspCtrlRData     = dspRData_ff;

	////////////////////////////////////////////////////////////////////////
	// Core release and memory clock request

	assign releaseWr = (state_ff == host_port_pkg::ST_PUSH) & fifoInReady &
		~isRead_ff & (accAddr_ff == `HP_RELEASE_ADDR);
	assign inIdleLight = lowPowerState[0] | lowPowerState[1];

	always_comb
	begin
		nxt_coreHold = coreHold_ff;
		// Pins level is caught on the first edge after the port wakes
		if (!strapDone_ff)
			nxt_coreHold = {2{coreResetPinsHigh}};
		else if (releaseWr)
			nxt_coreHold[subsystemSelect] = 1'b0;
		// Light idle: clocks only while an access is in flight
		if (inIdleLight)
			nxt_memClock = (state_ff != host_port_pkg::ST_IDLE) |
				startEdge | dmaReqValid;
		else
			nxt_memClock = ~lowPowerState[2];
	end

	always_ff @(posedge clk)
	begin
		if (portRst)
		begin
			coreHold_ff  <= `HP_CORE_HOLD_RST;
			strapDone_ff <= 1'b0;
			memClock_ff  <= 1'b0;
		end
		else
		begin
			coreHold_ff  <= nxt_coreHold;
			strapDone_ff <= 1'b1;
			memClock_ff  <= nxt_memClock;
		end
	end

	assign coreHold   = coreHold_ff;
	assign memClockOn = memClock_ff;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	a_todsp_reads_zero: assert property (
		@(posedge clk) disable iff (portRst)
		(state_ff == host_port_pkg::ST_IDLE) && startEdge &&
		addrDataMuxSelect && (effType == `HP_TYPE_CTRL) && effRead |=>
		!hostDataOut_ff[`HP_CTRL_TODSP] && !dspCtrlRData[`HP_CTRL_TODSP])
		else $error("to-DSP bit read back as one");

	a_todsp_pulse: assert property (
		@(posedge clk) disable iff (portRst)
		hostCtrlWr && hostDataLinesIn[`HP_CTRL_TODSP] |=>
		toDspInterrupt ##1 !toDspInterrupt)
		else $error("to-DSP interrupt not a single pulse");

	a_tohost_set: assert property (
		@(posedge clk) disable iff (portRst)
		dspCtrlWrite && dspCtrlWData[`HP_CTRL_TOHOST] |=> !toHostInterruptN)
		else $error("to-host pin not raised by DSP write");

	a_zero_no_effect: assert property (
		@(posedge clk) disable iff (portRst)
		(dspCtrlWrite || hostCtrlWr) &&
		!(dspCtrlWrite && dspCtrlWData[`HP_CTRL_TOHOST]) &&
		!(hostCtrlWr && hostDataLinesIn[`HP_CTRL_TOHOST]) |=>
		$stable(toHostInterruptN))
		else $error("zero write moved to-host bit");

	a_hold_on_read: assert property (
		@(posedge clk) disable iff (portRst)
		(state_ff == host_port_pkg::ST_WAIT) && !dmaRdValid |=>
		hostHoldOff && hostDataLinesOeN)
		else $error("host not held while read outstanding");

	a_autoinc_step: assert property (
		@(posedge clk) disable iff (portRst)
		(state_ff == host_port_pkg::ST_WAIT) && dmaRdValid && isAuto_ff |=>
		pointer_ff == $past(pointer_ff) + 18'h00001)
		else $error("pointer did not advance by one");

	a_sep_addr_used: assert property (
		@(posedge clk) disable iff (portRst)
		(state_ff == host_port_pkg::ST_IDLE) && startEdge &&
		!addrDataMuxSelect |=> accAddr_ff == $past(hostAddressLines) &&
		(state_ff == host_port_pkg::ST_PUSH))
		else $error("separate-mode address not taken");

	a_no_ctrl_sep: assert property (
		@(posedge clk) disable iff (portRst)
		startEdge && !addrDataMuxSelect && !dspCtrlWrite |=>
		$stable(prefetch_ff) && $stable(toHostBit_ff) && !toDspInterrupt)
		else $error("control word touched in separate mode");

	a_release_write: assert property (
		@(posedge clk) disable iff (portRst)
		releaseWr && strapDone_ff |=> !coreHold[$past(subsystemSelect)])
		else $error("release write did not free core");

	a_idle_clocks: assert property (
		@(posedge clk) disable iff (portRst)
		inIdleLight && (state_ff == host_port_pkg::ST_PUSH) |=> memClockOn)
		else $error("memory clocks off during idle access");

endmodule // host_port

// File: rtl/host_port_cfg.svh
// Constants for the host port: field positions, codes, reset values
// What this block does
// - Slave port moving 16-bit words to memory
// - Mux select pin picks multiplexed or separate
// - Separate mode takes 18-bit address from lines
// - Multiplexed mode keeps autoincrementing 18-bit pointer
// - Ready output stalls host through DMA latency
// - Control word only in multiplexed mode
// - Multiplexed access type chosen by type lines
// - Host one in to-DSP bit interrupts DSP
// - To-DSP bit always reads as zero
// - DSP sets to-host interrupt, host clears it
// - Writing zero leaves to-host bit unchanged
// - Separate mode: data lines, address lines, direction
// - Every data-window host access becomes a DMA access
// - No access to any I/O space
// - Memory clocks on per access in light idle
// - Own port reset, core may stay held
// - Keeps serving while CPU is halted
// - With reset pins high, each core held until host writes location 0x2F with it selected
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

`define HP_DATA_W        16
`define HP_ADDR_W        18
`define HP_FIFO_DEPTH    8
`define HP_FIFO_W        35

`define HP_TYPE_CTRL     2'h0
`define HP_TYPE_DATA_INC 2'h1
`define HP_TYPE_ADDR     2'h2
`define HP_TYPE_DATA     2'h3

`define HP_CTRL_PAGE_LO  0
`define HP_CTRL_PAGE_HI  1
`define HP_CTRL_PREFETCH 2
`define HP_CTRL_TODSP    3
`define HP_CTRL_TOHOST   4

`define HP_RELEASE_ADDR  18'h0002f
`define HP_CORE_HOLD_RST 2'h3
`define HP_POINTER_RST   18'h00000
`define HP_WORD_RST      16'h0000

`endif

// File: rtl/host_port_pkg.sv
// Types shared by the host port modules
package host_port_pkg;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_PUSH = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_END  = 4'b1000
	} access_state_t;

endpackage

// File: rtl/host_port_fifo.sv
// Request FIFO between the host side and the DMA side
`timescale 1ns/1ps
module host_port_fifo
#(
	parameter int WIDTH = 35,
	parameter int DEPTH = 8
)
(
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             inValid,
	output      logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output      logic             outValid,
	input  wire logic             outReady,
	output      logic [WIDTH-1:0] outData
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0]    wrPtr_ff;
	logic [PW-1:0]    nxt_wrPtr;
	logic [PW-1:0]    rdPtr_ff;
	logic [PW-1:0]    nxt_rdPtr;
	logic [CW-1:0]    count_ff;
	logic [CW-1:0]    nxt_count;
	logic             doWrite;
	logic             doRead;

	assign inReady  = (count_ff != FULL_COUNT);
	assign outValid = (count_ff != '0);
	assign outData  = mem_ff[rdPtr_ff];
	assign doWrite  = inValid & inReady;
	assign doRead   = outValid & outReady;

	always_comb
	begin
		nxt_wrPtr = wrPtr_ff;
		nxt_rdPtr = rdPtr_ff;
		nxt_count = count_ff;
		if (doWrite)
			nxt_wrPtr = (wrPtr_ff == LAST_PTR) ? '0 : PW'(wrPtr_ff + 1'b1);
		if (doRead)
			nxt_rdPtr = (rdPtr_ff == LAST_PTR) ? '0 : PW'(rdPtr_ff + 1'b1);
		if (doWrite && !doRead)
			nxt_count = CW'(count_ff + 1'b1);
		else if (doRead && !doWrite)
			nxt_count = CW'(count_ff - 1'b1);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end
		else
		begin
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
		end
	end

	// Storage entries; contents need no reset
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_entry
		always_ff @(posedge clk)
		begin
			if (doWrite && (wrPtr_ff == PW'(i)))
				mem_ff[i] <= inData;
		end
	end

endmodule // host_port_fifo

// File: sim/dma_mem_model.sv
// Memory model standing behind the host port's DMA request path
`timescale 1ns/1ps
module dma_mem_model
#(
	parameter int LAT = 4
)
(
	input  wire logic        clk,
	input  wire logic        stall,
	input  wire logic        reqValid,
	output      logic        reqReady,
	input  wire logic        reqWrite,
	input  wire logic [17:0] reqAddr,
	input  wire logic [15:0] reqData,
	output      logic        rdValid,
	output      logic [15:0] rdData
);
	logic [15:0] mem [logic [17:0]];
	logic [15:0] held;
	int          cnt;

	assign reqReady = !stall;
	initial
	begin
		rdValid = 1'b0;
		rdData  = 16'h0000;
		cnt     = 0;
	end
	always @(posedge clk)
	begin
		rdValid <= 1'b0;
		// Read data is meaningless between answers
		rdData  <= ~rdData;
		if (cnt > 0)
		begin
			cnt = cnt - 1;
			if (cnt == 0)
			begin
				rdValid <= 1'b1;
				rdData  <= held;
			end
		end
		if (reqValid && reqReady)
		begin
			if (reqWrite)
				mem[reqAddr] = reqData;
			else
			begin
				held = mem.exists(reqAddr) ? mem[reqAddr] : 16'h0000;
				cnt  = LAT;
			end
		end
	end
endmodule // dma_mem_model

// File: sim/host_port_interface_bench.sv
// Self-checking bench for the host port
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module host_port_interface_bench;
	logic        clk, srst, rstN, mux, csN, ds1N, ds2N, rnw, latchN;
	logic        dspWr, halted, strap, sel, stall, stallHi, rdV, reqR;
	logic [1:0]  hType;
	logic [2:0]  lps;
	logic [15:0] hDin, dspWd, rdD, hDout, dspRd, reqD;
	logic [17:0] hAddr, reqA;
	logic        oeN, hold, intN, toDsp, wake, clkOn, reqV, reqW;
	logic [1:0]  coreHold;
	logic [15:0] exp [$];
	logic [15:0] wd [10];
	logic [15:0] keep;
	logic [31:0] seed;
	int          nFail, checked, nDsp, nWake, nClk, w, i;
	bit          oeWas;

	host_port dut (.clk(clk), .srst(srst), .hostPortResetN(rstN),
		.addrDataMuxSelect(mux), .hostDataLinesIn(hDin),
		.hostDataLinesOut(hDout), .hostDataLinesOeN(oeN),
		.hostAddressLines(hAddr), .hostDataStrobeOneN(ds1N),
		.hostDataStrobeTwoN(ds2N), .hostChipSelectN(csN),
		.hostAccessType(hType), .hostReadNotWrite(rnw),
		.hostAddrLatchN(latchN), .hostHoldOff(hold),
		.toHostInterruptN(intN), .dspCtrlWrite(dspWr),
		.dspCtrlWData(dspWd), .dspCtrlRData(dspRd), .toDspInterrupt(toDsp),
		.dspWakeRequest(wake), .lowPowerState(lps), .cpuHalted(halted),
		.memClockOn(clkOn), .coreResetPinsHigh(strap),
		.subsystemSelect(sel), .coreHold(coreHold), .dmaReqValid(reqV),
		.dmaReqReady(reqR), .dmaReqWrite(reqW), .dmaReqAddr(reqA),
		.dmaReqData(reqD), .dmaRdValid(rdV), .dmaRdData(rdD));
	dma_mem_model mem (.clk(clk), .stall(stall), .reqValid(reqV),
		.reqReady(reqR), .reqWrite(reqW), .reqAddr(reqA), .reqData(reqD),
		.rdValid(rdV), .rdData(rdD));

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1)
		begin
			nFail++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", checked, nFail);
		if (nFail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One host access; for reads d is the expected word
	task automatic hacc(input logic rd, input logic [1:0] ty,
		input logic [17:0] a, input logic [15:0] d);
		@(negedge clk);
		hType  = ty;
		rnw    = rd;
		hAddr  = a;
		hDin   = rd ? ~d : d;
		latchN = 1'b0;
		if (rd)
			exp.push_back(d);
		@(negedge clk);
		latchN = 1'b1;
		csN    = 1'b0;
		if (rd)
			ds2N = 1'b0;
		else
			ds1N = 1'b0;
		w = 0;
		do @(negedge clk);
		while (hold !== 1'b0 && ++w < 300);
		if (w >= 300)
			chk(1'b0, "host access hung");
		@(negedge clk);
		csN  = 1'b1;
		ds1N = 1'b1;
		ds2N = 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(negedge clk)
		stall = stallHi | rnd() % 3 == 0;
	always @(posedge clk)
	begin
		nDsp  += toDsp;
		nWake += wake;
		nClk  += clkOn;
	end
	// Read data is looked at half a cycle after it settles
	always @(negedge clk)
	begin
		if (oeN === 1'b0 && oeWas)
		begin
			if (exp.size() == 0)
				chk(1'b0, "read data with nothing expected");
			else
				chk(hDout === exp.pop_front(), "read data");
		end
		oeWas = (oeN !== 1'b0);
	end
	initial
	begin
		#200000;
		nFail++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////
	initial
	begin
		{srst, rstN, csN, ds1N, ds2N, latchN, strap} = 7'h7f;
		{mux, rnw, dspWr, halted, sel, stallHi} = 6'h00;
		{hType, lps, hDin, dspWd, hAddr} = 55'h0;
		{nFail, checked, nDsp, nWake, nClk} = 0;
		seed = 32'hdee38812;
		repeat (5) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk(coreHold === 2'h3, "cores not held");
		// Separate buses: 18-bit addresses straight from the lines
		for (i = 0; i < 5; i++)
		begin
			wd[i] = rnd();
			hAddr = (i == 4) ? 18'h3ffff : rnd() | 18'h00100;
			hacc(1'b0, `HP_TYPE_DATA, hAddr, wd[i]);
			hacc(1'b1, `HP_TYPE_CTRL, hAddr, wd[i]);
			chk(w >= 4, "read not held off");
		end
		keep = wd[4];
		chk(coreHold === 2'h3, "cores released early");
		sel = 1'b1;
		hacc(1'b0, `HP_TYPE_DATA, `HP_RELEASE_ADDR, rnd());
		chk(coreHold === 2'h1, "select one release");
		sel = 1'b0;
		hacc(1'b0, `HP_TYPE_DATA, `HP_RELEASE_ADDR, rnd());
		chk(coreHold === 2'h0, "select zero release");
		// Multiplexed: page 2 pointer, FIFO filled while DMA stalls
		mux    = 1'b1;
		halted = 1'b1;
		hacc(1'b0, `HP_TYPE_CTRL, 18'h0, 16'h0002);
		hacc(1'b0, `HP_TYPE_ADDR, 18'h0, 16'h1230);
		stallHi = 1'b1;
		fork
			for (i = 0; i < 9; i++)
			begin
				wd[i] = rnd();
				hacc(1'b0, `HP_TYPE_DATA_INC, 18'h0, wd[i]);
				chk((w > 20) == (i == 8), "FIFO back-pressure");
			end
			begin
				repeat (70) @(negedge clk);
				stallHi = 1'b0;
			end
		join
		wd[9] = rnd();
		hacc(1'b0, `HP_TYPE_DATA, 18'h0, wd[9]);
		hacc(1'b1, `HP_TYPE_ADDR, 18'h0, 16'h1239);
		hacc(1'b1, `HP_TYPE_DATA, 18'h0, wd[9]);
		hacc(1'b0, `HP_TYPE_ADDR, 18'h0, 16'h1230);
		lps = 3'h1;
		nClk = 0;
		for (i = 0; i < 10; i++)
			hacc(1'b1, `HP_TYPE_DATA_INC, 18'h0, wd[i]);
		repeat (2) @(negedge clk);
		chk(nClk > 0 && clkOn === 1'b0, "clock gating");
		// Interrupts through the control word
		lps = 3'h4;
		hacc(1'b0, `HP_TYPE_CTRL, 18'h0, 16'h000e);
		chk(nDsp == 1 && nWake == 1, "to-DSP pulse");
		hacc(1'b1, `HP_TYPE_CTRL, 18'h0, 16'h0006);
		dspWd = 16'h0010;
		dspWr = 1'b1;
		@(negedge clk);
		dspWr = 1'b0;
		repeat (2) @(negedge clk);
		chk(intN === 1'b0, "to-host set");
		hacc(1'b0, `HP_TYPE_CTRL, 18'h0, 16'h0006);
		dspWd = 16'h0000;
		dspWr = 1'b1;
		@(negedge clk);
		dspWr = 1'b0;
		@(negedge clk);
		chk(intN === 1'b0, "zero write cleared");
		chk(dspRd === 16'h0016, "DSP view of control");
		hacc(1'b1, `HP_TYPE_CTRL, 18'h0, 16'h0016);
		hacc(1'b0, `HP_TYPE_CTRL, 18'h0, 16'h0016);
		chk(intN === 1'b1, "to-host clear");
		// Port reset alone, strap low
		strap = 1'b0;
		rstN  = 1'b0;
		repeat (2) @(negedge clk);
		chk(coreHold === 2'h3 && oeN === 1'b1, "port reset");
		rstN = 1'b1;
		repeat (2) @(negedge clk);
		chk(coreHold === 2'h0, "strap low release");
		mux = 1'b0;
		hacc(1'b1, `HP_TYPE_DATA, 18'h3ffff, keep);
		repeat (4) @(negedge clk);
		chk(exp.size() == 0, "reads unanswered");
		summarize();
	end
endmodule // host_port_interface_bench
